// file: logic/sfp_cfg.svh
// timing counts, pin positions and defaults of the serial flash pin interface
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH
`define SFP_CLK_MHZ      100
`define SFP_RST_MIN_NS   1000
`define SFP_RST_MIN_CYC  ((`SFP_RST_MIN_NS * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_RECOVER_NS   28000
`define SFP_RECOVER_CYC  ((`SFP_RECOVER_NS * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_DUMMY_QUAD   3'h3
`define SFP_DUMMY_STD    3'h1
`define SFP_PAGE_MAX     9'h100
`define SFP_PAGE_SAT     9'h101
`define SFP_FIFO_DEPTH   8
`define SFP_BYTE_BITS    4'h8
`define SFP_LANE_SI      0
`define SFP_LANE_WP      2
`define SFP_LANE_HOLD    3
`define SFP_MASK_SINGLE  4'h2
`define SFP_MASK_DUAL    4'h3
`define SFP_MASK_QUAD    4'hf
`define SFP_SEL_RESET    1'b1
`endif

// file: logic/sfp_pkg.sv
// types shared by the serial flash pin interface
package sfp_pkg;
  typedef enum logic [1:0] {SFP_LANE_SINGLE, SFP_LANE_DUAL, SFP_LANE_QUAD} sfp_lane_mode_t;
  typedef enum logic [2:0] {PH_IDLE, PH_IN, PH_DUMMY, PH_OUT, PH_RECOVER} sfp_phase_t;
endpackage

// file: logic/sfp_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst_b,  // async reset, active low
  input  wire logic [W-1:0] d,      // asynchronous input
  output logic      [W-1:0] q       // synchronised output
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfp_sync_t;
  sfp_sync_t st_ff;
  sfp_sync_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule // sfp_sync
`default_nettype wire

// file: logic/sfp_fifo.sv
// small show-ahead fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sfp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,        // system clock
  input  wire logic         rst_b,      // async reset, active low
  input  wire logic         clear,      // flush all entries
  input  wire logic         in_valid,   // write request
  input  wire logic [W-1:0] in_data,    // write data
  output logic              in_ready,   // room for a word
  output logic              out_valid,  // word available
  output logic      [W-1:0] out_data,   // oldest word
  input  wire logic         out_ready   // reader takes word
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } sfp_fifo_t;
  sfp_fifo_t st_ff;
  sfp_fifo_t nxt_st;
  logic      full;
  logic      empty;

  assign empty     = st_ff.wp == st_ff.rp;
  assign full      = (st_ff.wp[AW] != st_ff.rp[AW]) && (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st_ff.mem[st_ff.rp[AW-1:0]];

  always_comb begin
    nxt_st = st_ff;
    if (clear) begin
      nxt_st.wp = '0;
      nxt_st.rp = '0;
    end else begin
      if (in_valid && !full) begin
        nxt_st.mem[st_ff.wp[AW-1:0]] = in_data;
        nxt_st.wp                    = st_ff.wp + 1'b1;
      end
      if (out_ready && !empty) begin
        nxt_st.rp = st_ff.rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  property p_no_overfill;
    @(posedge clk) disable iff (!rst_b)
    full && !out_ready && !clear |=> full && $stable(st_ff.wp);
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("fifo write past full");
endmodule // sfp_fifo
`default_nettype wire

// file: logic/sfp_pin_if.sv
// pin-level serial interface of a serial flash, device side
// Notes on behaviour
// - serial clock may idle low or high; both work unchanged.
// - single lane: command, address, write bits sampled on clock rise.
// - single lane: read data changes on clock fall on output lane.
// - dual/quad lanes are two-way; sample on rise, drive on fall.
// - select high: deselected, every lane floats.
// - commands and read data only while select low.
// - after power-up, nothing accepted before select goes high to low.
// - write-protect low with status lock bit set blocks status writes; with protect bits, hardware protection.
// - write-protect only in single/dual; quad uses it as lane 2.
// - shared pin pauses when disable bit 0 and select bit 0.
// - pause low while selected floats output, ignores input and clock.
// - pause only in single/dual; quad uses it as lane 3.
// - shared pin resets when disable bit 0 and select bit 1.
// - reset pin only in single/dual; quad uses it as lane 3.
// - reset held low at least 1us aborts everything, back to initial; prog_bytes, prog_len_ok and rx_overrun keep their values here.
// - no new command until 28us after reset pin rises.
// - page program writes 1 to 256 data bytes.
// - fast read dummy bytes: 3 in quad, 1 otherwise; configurable.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_cfg.svh"
module sfp_pin_if #(
  parameter int RST_MIN_CYC = `SFP_RST_MIN_CYC,
  parameter int RECOVER_CYC = `SFP_RECOVER_CYC,
  parameter int FIFO_DEPTH  = `SFP_FIFO_DEPTH
) (
  input  wire logic                    clk,                   // system clock 100 MHz
  input  wire logic                    rst_b,                 // async reset, active low
  input  wire logic                    sclk,                  // serial clock pin
  input  wire logic                    cs_b,                  // chip select pin, active low
  input  wire logic [3:0]              io_lanes_in,           // lane pin levels
  output logic      [3:0]              io_lanes_out,          // lane drive values
  output logic      [3:0]              io_lanes_oe,           // lane drive enables
  input  wire sfp_pkg::sfp_lane_mode_t lane_mode,             // single, dual or quad
  input  wire logic                    pin_function_disable,  // shared pin function off
  input  wire logic                    pause_or_rst_select,   // 0 pause, 1 reset
  input  wire logic                    status_lock_bit,       // status lock bit
  input  wire logic [3:0]              block_protect_bits,    // block protect bits
  input  wire logic [2:0]              dummy_bytes,           // 0 selects mode default
  input  wire logic                    out_req,               // pulse: start read phase
  input  wire logic                    out_dummy,             // read phase has dummy bytes
  input  wire logic [7:0]              tx_data,               // next read byte
  input  wire logic                    tx_valid,              // read byte present
  output logic                         tx_ready,              // read byte taken
  output logic      [7:0]              rx_data,               // received byte
  output logic                         rx_valid,              // received byte present
  input  wire logic                    rx_ready,              // user takes byte
  input  wire logic                    page_prog,             // count program data bytes
  output logic      [8:0]              prog_bytes,            // data bytes counted
  output logic                         prog_len_ok,           // last program 1..256 bytes
  output logic                         rx_overrun,            // byte lost to full fifo
  output logic                         hold_active,           // paused
  output logic                         hw_reset_busy,         // reset or recovery running
  output logic                         sr_write_blocked,      // status writes refused
  output logic                         hw_protect_active      // array hardware protected
);
  import sfp_pkg::*;

  typedef struct packed {
    sfp_phase_t ph;
    logic       cs_prev;
    logic       sclk_prev;
    logic [7:0] sh_in;
    logic [3:0] in_bits;
    logic [7:0] sh_out;
    logic [3:0] out_bits;
    logic [5:0] dum_bits;
    logic [3:0] lanes_o;
    logic [11:0] rcnt;
    logic [8:0] prog_cnt;
    logic       prog_ok;
    logic       overrun;
    logic       wp_blk;
    logic       hw_prot;
  } sfp_core_t;

  sfp_core_t  st_ff;
  sfp_core_t  nxt_st;
  logic [5:0] pins_s;
  logic       sclk_s;
  logic       cs_s;
  logic [3:0] lanes_s;
  logic       quad;
  logic       hold;
  logic       rst_en;
  logic       rise;
  logic       fall;
  logic       cs_fall;
  logic       cs_rise;
  logic [3:0] step;
  logic [3:0] mask;
  logic [7:0] in_byte;
  logic [7:0] ld_byte;
  logic [2:0] dcount;
  logic [5:0] dtarget;
  logic       push;
  logic       push_ready;
  logic       flush;

  // ==========================================================
  // pin synchronisers
  sfp_sync #(.W(6)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({sclk, cs_b, io_lanes_in}),
    .q     (pins_s)
  );
  assign sclk_s  = pins_s[5];
  assign cs_s    = pins_s[4];
  assign lanes_s = pins_s[3:0];

  // ==========================================================
  // pin functions and lane widths
  assign quad   = lane_mode == SFP_LANE_QUAD;
  assign hold   = !pin_function_disable && !pause_or_rst_select && !quad &&
                  !cs_s && !lanes_s[`SFP_LANE_HOLD];
  assign rst_en = !pin_function_disable && (pause_or_rst_select == `SFP_SEL_RESET) && !quad;

  assign rise    = sclk_s && !st_ff.sclk_prev && !cs_s && !hold;
  assign fall    = !sclk_s && st_ff.sclk_prev && !cs_s && !hold;
  assign cs_fall = !cs_s && st_ff.cs_prev;
  assign cs_rise = cs_s && !st_ff.cs_prev;

  always_comb begin
    step    = 4'h1;
    mask    = `SFP_MASK_SINGLE;
    in_byte = {st_ff.sh_in[6:0], lanes_s[`SFP_LANE_SI]};
    dcount  = `SFP_DUMMY_STD;
    unique case (lane_mode)
      SFP_LANE_DUAL: begin
        step    = 4'h2;
        mask    = `SFP_MASK_DUAL;
        in_byte = {st_ff.sh_in[5:0], lanes_s[1:0]};
      end
      SFP_LANE_QUAD: begin
        step    = 4'h4;
        mask    = `SFP_MASK_QUAD;
        in_byte = {st_ff.sh_in[3:0], lanes_s};
        dcount  = `SFP_DUMMY_QUAD;
      end
      default: begin
      end
    endcase
    if (dummy_bytes != 3'h0) begin
      dcount = dummy_bytes;
    end
  end
  assign dtarget = {dcount, 3'h0};
  assign ld_byte = tx_valid ? tx_data : 8'hff;

  // ==========================================================
  // transfer sequencing
  always_comb begin
    nxt_st           = st_ff;
    push             = 1'b0;
    flush            = 1'b0;
    tx_ready         = 1'b0;
    nxt_st.cs_prev   = cs_s;
    nxt_st.sclk_prev = sclk_s;
    nxt_st.wp_blk    = !lanes_s[`SFP_LANE_WP] && status_lock_bit && !quad;
    nxt_st.hw_prot   = nxt_st.wp_blk && (|block_protect_bits);
    unique case (st_ff.ph)
      PH_IDLE: begin
        if (cs_fall) begin
          nxt_st.ph       = PH_IN;
          nxt_st.in_bits  = 4'h0;
          nxt_st.prog_cnt = 9'h000;
          nxt_st.overrun  = 1'b0;
        end
      end
      PH_IN, PH_DUMMY, PH_OUT: begin
        if (cs_rise) begin
          nxt_st.ph      = PH_IDLE;
          nxt_st.prog_ok = (st_ff.prog_cnt != 9'h000) && (st_ff.prog_cnt <= `SFP_PAGE_MAX);
        end else if (st_ff.ph == PH_IN) begin
          if (out_req) begin
            nxt_st.ph       = out_dummy ? PH_DUMMY : PH_OUT;
            nxt_st.dum_bits = 6'h00;
            nxt_st.out_bits = 4'h0;
          end else if (rise) begin
            nxt_st.sh_in   = in_byte;
            nxt_st.in_bits = st_ff.in_bits + step;
            if (st_ff.in_bits + step == `SFP_BYTE_BITS) begin
              nxt_st.in_bits = 4'h0;
              push           = 1'b1;
              if (!push_ready) begin
                nxt_st.overrun = 1'b1;
              end
              if (page_prog && st_ff.prog_cnt != `SFP_PAGE_SAT) begin
                nxt_st.prog_cnt = st_ff.prog_cnt + 9'h001;
              end
            end
          end
        end else if (st_ff.ph == PH_DUMMY) begin
          if (rise) begin
            nxt_st.dum_bits = st_ff.dum_bits + {2'h0, step};
            if (st_ff.dum_bits + {2'h0, step} >= dtarget) begin
              nxt_st.ph = PH_OUT;
            end
          end
        end else if (fall) begin
          if (st_ff.out_bits == 4'h0) begin
            tx_ready       = tx_valid;
            nxt_st.sh_out  = ld_byte << step;
            nxt_st.lanes_o = quad ? ld_byte[7:4] :
                             (step == 4'h2) ? {2'h0, ld_byte[7:6]} : {2'h0, ld_byte[7], 1'b0};
          end else begin
            nxt_st.sh_out  = st_ff.sh_out << step;
            nxt_st.lanes_o = quad ? st_ff.sh_out[7:4] :
                             (step == 4'h2) ? {2'h0, st_ff.sh_out[7:6]} :
                             {2'h0, st_ff.sh_out[7], 1'b0};
          end
          nxt_st.out_bits = (st_ff.out_bits + step) & 4'h7;
        end
      end
      PH_RECOVER: begin
        if (!lanes_s[`SFP_LANE_HOLD] && rst_en) begin
          nxt_st.rcnt = 12'h000;
        end else if (st_ff.rcnt == 12'(RECOVER_CYC - 1)) begin
          nxt_st.ph   = PH_IDLE;
          nxt_st.rcnt = 12'h000;
        end else begin
          nxt_st.rcnt = st_ff.rcnt + 12'h001;
        end
      end
    endcase
    if (st_ff.ph != PH_RECOVER) begin
      if (rst_en && !lanes_s[`SFP_LANE_HOLD]) begin
        nxt_st.rcnt = st_ff.rcnt + 12'h001;
        if (st_ff.rcnt == 12'(RST_MIN_CYC - 1)) begin
          nxt_st.ph       = PH_RECOVER;
          nxt_st.rcnt     = 12'h000;
          nxt_st.in_bits  = 4'h0;
          nxt_st.out_bits = 4'h0;
          nxt_st.lanes_o  = 4'h0;
          push            = 1'b0;
          tx_ready        = 1'b0;
          flush           = 1'b1;
        end
      end else begin
        nxt_st.rcnt = 12'h000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // receive buffer
  sfp_fifo #(.W(8), .D(FIFO_DEPTH)) u_rx_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .clear     (flush),
    .in_valid  (push),
    .in_data   (in_byte),
    .in_ready  (push_ready),
    .out_valid (rx_valid),
    .out_data  (rx_data),
    .out_ready (rx_ready)
  );

  // ==========================================================
  // outputs
  // float unless reading
  assign io_lanes_oe       = (st_ff.ph == PH_OUT && !cs_s && !hold) ? mask : 4'h0;
  assign io_lanes_out      = st_ff.lanes_o;
  assign prog_bytes        = st_ff.prog_cnt;
  assign prog_len_ok       = st_ff.prog_ok;
  assign rx_overrun        = st_ff.overrun;
  assign hold_active       = hold;
  assign hw_reset_busy     = st_ff.ph == PH_RECOVER;
  assign sr_write_blocked  = st_ff.wp_blk;
  assign hw_protect_active = st_ff.hw_prot;

  // ==========================================================
  // checks
  property p_float_desel;
    @(posedge clk) disable iff (!rst_b)
    cs_s |-> io_lanes_oe == 4'h0;
  endproperty
  a_float_desel: assert property (p_float_desel) else $error("lane driven while deselected");

  property p_pause_freeze;
    @(posedge clk) disable iff (!rst_b)
    hold && st_ff.ph == PH_IN |=> $stable(st_ff.sh_in) && io_lanes_oe == 4'h0;
  endproperty
  a_pause_freeze: assert property (p_pause_freeze) else $error("input moved in pause");

  property p_sample_rise;
    @(posedge clk) disable iff (!rst_b)
    st_ff.ph == PH_IN && rise && !out_req && !cs_rise && lane_mode == SFP_LANE_SINGLE &&
    !(rst_en && !lanes_s[3]) |=> st_ff.sh_in[0] == $past(lanes_s[0]);
  endproperty
  a_sample_rise: assert property (p_sample_rise) else $error("serial input not sampled");

  property p_drive_fall;
    @(posedge clk) disable iff (!rst_b)
    st_ff.ph == PH_OUT && !fall && !(rst_en && !lanes_s[3]) |=> $stable(io_lanes_out);
  endproperty
  a_drive_fall: assert property (p_drive_fall) else $error("output moved off a fall");

  property p_need_fall;
    @(posedge clk) disable iff (!rst_b)
    st_ff.ph == PH_IDLE && !cs_fall |=> st_ff.ph != PH_IN;
  endproperty
  a_need_fall: assert property (p_need_fall) else $error("opened without select fall");

  property p_wp_block;
    @(posedge clk) disable iff (!rst_b)
    !lanes_s[2] && status_lock_bit && !quad ##1 !quad |-> sr_write_blocked;
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("status write not blocked");

  property p_quad_nowp;
    @(posedge clk) disable iff (!rst_b)
    quad ##1 quad |-> !sr_write_blocked;
  endproperty
  a_quad_nowp: assert property (p_quad_nowp) else $error("protect active in quad");

  property p_rst_abort;
    @(posedge clk) disable iff (!rst_b)
    st_ff.ph != PH_RECOVER && rst_en && !lanes_s[3] && st_ff.rcnt == 12'(RST_MIN_CYC - 1)
    |=> st_ff.ph == PH_RECOVER && io_lanes_oe == 4'h0;
  endproperty
  a_rst_abort: assert property (p_rst_abort) else $error("reset pulse not honoured");

  property p_recover_len;
    @(posedge clk) disable iff (!rst_b)
    $past(st_ff.ph) == PH_RECOVER && st_ff.ph == PH_IDLE |->
    $past(st_ff.rcnt) == 12'(RECOVER_CYC - 1);
  endproperty
  a_recover_len: assert property (p_recover_len) else $error("recovery ended early");

  property p_dummy_len;
    @(posedge clk) disable iff (!rst_b)
    st_ff.ph == PH_DUMMY ##1 st_ff.ph == PH_OUT |-> $past(st_ff.dum_bits) + 6'(step) >= dtarget;
  endproperty
  a_dummy_len: assert property (p_dummy_len) else $error("dummy phase too short");
endmodule // sfp_pin_if
`default_nettype wire

// file: tb/sfp_master.sv
// spi bus master model driving the flash pins
`timescale 1ns/1ps
`default_nettype none
module sfp_master (
  input  wire logic       clk,    // system clock
  input  wire logic [3:0] lanes,  // resolved lane levels
  output logic            sclk,   // serial clock
  output logic            cs_b,   // chip select, active low
  output logic      [3:0] drv,    // lane drive values
  output logic      [3:0] drv_oe  // lane drive enables
);
  logic quad = 1'b0;  // quad lanes in use
  logic wp   = 1'b1;  // write-protect level
  logic hold = 1'b1;  // pause/reset level
  logic pol  = 1'b0;  // clock idle level
  initial begin
    sclk = 1'b0;
    cs_b = 1'b0;
    drv = 4'hc;
    drv_oe = 4'hc;
  end
  // side pins driven only outside quad
  task automatic pins(input logic w, input logic h);
    wp = w;
    hold = h;
    drv = {h, w, 2'b00};
    drv_oe = quad ? 4'h0 : 4'hc;
  endtask
  // clock parked at idle level, then select falls
  task automatic sel(input logic p);
    pol = p;
    sclk = p;
    cs_b = 1'b1;
    repeat (6) @(negedge clk);
    cs_b = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  // select rises only after the last edge has settled
  task automatic desel();
    repeat (8) @(negedge clk);
    cs_b = 1'b1;
    sclk = pol;
    repeat (8) @(negedge clk);
  endtask
  // change after fall, sample at rise, msb first
  task automatic xfer(input int w, input int n, input logic [7:0] d,
                      input logic dr, output logic [7:0] q);
    logic [3:0] m;
    logic [3:0] g;
    m = 4'((1 << w) - 1);
    q = 8'h00;
    for (int i = 0; i < n; i += w) begin
      g = 4'(d >> (8 - i - w)) & m;
      sclk = 1'b0;
      if (dr) begin
        drv = quad ? g : ({hold, wp, 2'b00} | g);
        drv_oe = quad ? m : (4'hc | m);
      end
      repeat (8) @(negedge clk);
      sclk = 1'b1;
      q = (q << w) | 8'(w == 1 ? 4'(lanes[1]) : (lanes & m));
      repeat (8) @(negedge clk);
    end
    pins(wp, hold);
  endtask
endmodule // sfp_master
`default_nettype wire

// file: tb/tb.sv
// testbench of the serial flash pin interface
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfp_pkg::*;
  logic           clk = 1'b0;
  logic           rst_b = 1'b0;
  logic           sclk;
  logic           cs_b;
  logic     [3:0] lanes;
  logic     [3:0] out;
  logic     [3:0] oe;
  logic     [3:0] m_drv;
  logic     [3:0] m_oe;
  logic           flip = 1'b0;
  sfp_lane_mode_t lane_mode = SFP_LANE_SINGLE;
  logic           pfd = 1'b0;
  logic           psel = 1'b0;
  logic           lock = 1'b0;
  logic     [3:0] bp = 4'h0;
  logic     [2:0] dummy_bytes = 3'h0;
  logic           out_req = 1'b0;
  logic           out_dummy = 1'b0;
  logic     [7:0] tx_data = 8'h00;
  logic           tx_valid = 1'b0;
  logic           tx_ready;
  logic     [7:0] rx_data;
  logic           rx_valid;
  logic           rx_ready = 1'b0;
  logic           page_prog = 1'b0;
  logic     [8:0] prog_bytes;
  logic           prog_len_ok;
  logic           rx_overrun;
  logic           hold_active;
  logic           hw_reset_busy;
  logic           sr_write_blocked;
  logic           hw_protect_active;
  logic     [7:0] q;
  int             error_cnt = 0;
  int             cmp_count = 0;
  int             tx_taken = 0;
  int             cyc = 0;
  always #5 clk = ~clk;
  // count read bytes the device takes, sampled away from the launching edge
  always @(negedge clk) if (tx_ready === 1'b1) tx_taken++;
  always @(posedge clk) flip <= ~flip;
  // undriven lanes keep changing so no stale level survives
  assign lanes = (oe & out) | (~oe & m_oe & m_drv) | (~oe & ~m_oe & {4{flip}});
  sfp_pin_if #(.RST_MIN_CYC(4), .RECOVER_CYC(20), .FIFO_DEPTH(8)) i_dut (
    .clk, .rst_b, .sclk, .cs_b, .io_lanes_in(lanes), .io_lanes_out(out), .io_lanes_oe(oe),
    .lane_mode, .pin_function_disable(pfd), .pause_or_rst_select(psel),
    .status_lock_bit(lock), .block_protect_bits(bp), .dummy_bytes, .out_req, .out_dummy,
    .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .page_prog,
    .prog_bytes, .prog_len_ok, .rx_overrun, .hold_active, .hw_reset_busy,
    .sr_write_blocked, .hw_protect_active);
  sfp_master i_mst (.clk, .lanes, .sclk, .cs_b, .drv(m_drv), .drv_oe(m_oe));
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic get_rx(input logic [7:0] e);
    for (int k = 0; k < 300 && rx_valid !== 1'b1; k++) @(negedge clk);
    chk({rx_valid, rx_data}, {1'b1, e});
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    @(negedge clk);
  endtask
  task automatic put(input int w, input logic [7:0] d);
    i_mst.xfer(w, 8, d, 1'b1, q);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic setm(input int w);
    lane_mode = w == 4 ? SFP_LANE_QUAD : w == 2 ? SFP_LANE_DUAL : SFP_LANE_SINGLE;
    i_mst.quad = (w == 4);
    i_mst.pins(1'b1, 1'b1);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    int w;
    int r;
    int t;
    wt(20);
    rst_b = 1'b1;
    wt(4);
    // select low since power-up: byte must be ignored
    put(1, 8'h9a);
    wt(10);
    chk(9'(rx_valid), 9'h0);
    i_mst.desel();
    // reads in every lane mode, both clock idle levels, dummy counts
    for (int i = 0; i < 5; i++) begin
      w = (i == 1) ? 2 : (i == 2 || i == 3) ? 4 : 1;
      setm(w);
      dummy_bytes = (i == 3) ? 3'h2 : 3'h0;
      r = (i == 4) ? 0 : (i == 3) ? 2 : (w == 4) ? 3 : 1;
      i_mst.sel(i[0]);
      put(w, 8'ha5 - 8'(i));
      get_rx(8'ha5 - 8'(i));
      out_dummy = (r != 0);
      out_req = 1'b1;
      wt(1);
      out_req = 1'b0;
      i_mst.xfer(w, r * 8, 8'h00, 1'b0, q);
      tx_data = 8'h96 + 8'(i);
      // last read has no byte offered: the lanes must show all ones
      tx_valid = (i != 4);
      t = tx_taken;
      i_mst.xfer(w, 8, 8'h00, 1'b0, q);
      tx_valid = 1'b0;
      chk(9'(q), 9'(i == 4 ? 8'hff : 8'h96 + 8'(i)));
      chk(9'(tx_taken - t), 9'(i != 4));
      chk(9'(oe), 9'(w == 4 ? 4'hf : w == 2 ? 4'h3 : 4'h2));
      i_mst.desel();
      chk(9'(oe), 9'h0);
    end
    // pause mid-byte; clocks while paused are dropped
    setm(1);
    i_mst.sel(1'b0);
    i_mst.xfer(1, 4, 8'hc3, 1'b1, q);
    i_mst.pins(1'b1, 1'b0);
    wt(4);
    chk(9'(hold_active), 9'h1);
    i_mst.xfer(1, 4, 8'h00, 1'b1, q);
    i_mst.pins(1'b1, 1'b1);
    wt(4);
    i_mst.xfer(1, 4, 8'h30, 1'b1, q);
    get_rx(8'hc3);
    pfd = 1'b1;
    i_mst.pins(1'b1, 1'b0);
    wt(4);
    chk(9'(hold_active), 9'h0);
    i_mst.pins(1'b1, 1'b1);
    pfd = 1'b0;
    i_mst.desel();
    // reader stalls: ninth byte is lost, eight drain in order
    i_mst.sel(1'b0);
    for (int k = 0; k < 9; k++) put(1, 8'h40 + 8'(k));
    i_mst.desel();
    chk(9'(rx_overrun), 9'h1);
    for (int k = 0; k < 8; k++) get_rx(8'h40 + 8'(k));
    chk(9'(rx_valid), 9'h0);
    // page lengths 0, 1 and 257 in quad, lane 3 carrying data
    setm(4);
    rx_ready = 1'b1;
    page_prog = 1'b1;
    for (int n = 0; n < 3; n++) begin
      i_mst.sel(1'b0);
      for (int k = 0; k < (n == 2 ? 257 : n); k++) begin
        put(4, 8'(k));
        if (k >= 255) chk(prog_bytes, 9'(k + 1));
      end
      i_mst.desel();
      chk(9'(prog_len_ok), 9'(n == 1));
    end
    rx_ready = 1'b0;
    page_prog = 1'b0;
    // write-protect level against lock, protect bits and lane mode
    for (int i = 0; i < 5; i++) begin
      w = (i == 3) ? 4 : (i == 2) ? 2 : 1;
      setm(w);
      lock = (i != 2);
      bp = (i == 4) ? 4'h0 : 4'h2;
      i_mst.pins(i == 1, 1'b1);
      wt(6);
      chk(9'(sr_write_blocked), 9'(i != 1 && i != 2 && w != 4));
      chk(9'(hw_protect_active), 9'(i == 0));
    end
    // shared pin as reset: short pulse ignored, long one aborts
    setm(1);
    psel = 1'b1;
    i_mst.sel(1'b0);
    put(1, 8'h11);
    i_mst.desel();
    i_mst.pins(1'b1, 1'b0);
    wt(3);
    i_mst.pins(1'b1, 1'b1);
    wt(6);
    chk(9'(hw_reset_busy), 9'h0);
    chk(9'(rx_valid), 9'h1);
    // long low pulse with the pin in pause use, then switched off: no reset
    for (int s = 0; s < 2; s++) begin
      pfd = (s == 1);
      psel = (s == 1);
      i_mst.pins(1'b1, 1'b0);
      wt(8);
      i_mst.pins(1'b1, 1'b1);
      wt(6);
      chk(9'(hw_reset_busy), 9'h0);
    end
    pfd = 1'b0;
    i_mst.pins(1'b1, 1'b0);
    wt(8);
    i_mst.pins(1'b1, 1'b1);
    wt(15);
    chk(9'(hw_reset_busy), 9'h1);
    chk(9'(rx_valid), 9'h0);
    wt(15);
    chk(9'(hw_reset_busy), 9'h0);
    i_mst.sel(1'b0);
    put(1, 8'h22);
    get_rx(8'h22);
    i_mst.desel();
    end_sim();
  end
endmodule // tb
`default_nettype wire
